/* sync_io_interrupt_timer.sv */
// Card control logic: input polarity, cascade, debounce, timer, interrupts
// What this block does
// R1 - Polarity bits 0-5 make each external input low-active (0) or high-active
// R2 - Polarity bit 6 sets sync input level, bit 7 the cascade output level
// R3 - Input state word shows the six inputs as active after polarity
// R4 - Cascade source: 0 inactive, 1 active, 2 timer, 3 follows sync
// R5 - Host reads the current sync state as one bit
// R6 - Debounce preload is an 8-bit value 0 to 255
// R7 - A readable hardware revision byte lets software detect features
// R8 - All enabled interrupt sources are ORed into one request
// R9 - Enable bit 0 timer, bit 1 sync, bits 2-7 inputs 1-6
// R10 - Enable bits 8-13 are reference marks of axes 0-2, first even
// R11 - Enable bit 14 is the encoder error, bit 15 reserved
// R12 - Status bits use the enable layout and show the causing source
// R13 - Reading the status word clears all its bits
// R14 - Status sets only on a new edge, not a steady active source
// R15 - Zero preload stops a running timer at its next zero crossing
// R16 - Nonzero preload while stopped starts the timer at once
// R17 - Nonzero preload while running takes effect at the next crossing
// R18 - Timer period is (preload plus one) times 256 clock cycles
// R19 - Host reads the remaining count to the next crossing, 16 bits
// R20 - Each zero crossing gives a one-cycle timer event
// R21 - Zero debounce passes sync through; else drop-out is value times 16384
// R22 - Each sync activation retriggers the delay; drop only after expiry
// R23 - A source is captured on inactive-to-active only while enabled
// R24 - An edge coinciding with a status read stays set
// R25 - Reset clears enables, stops timer, cascade inactive, debounce zero
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module sync_io_interrupt_timer
  import sync_io_pkg::*;
#(
  parameter int DEBOUNCE_UNIT = DEBOUNCE_UNIT_DEFAULT
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [NUM_EXT-1:0] ext_input,
  input wire logic sync_input,
  input wire logic [NUM_REF-1:0] ref_mark,
  input wire logic encoder_error,
  output logic cascade_output,
  output logic sync_active,
  output logic timer_zero_event,
  output logic irq
);

  logic [7:0] input_polarity_setting;
  casc_src_e cascade_source_select;
  logic [7:0] sync_debounce_preload;
  logic [14:0] interrupt_enable_word;
  logic [14:0] interrupt_status_word;
  logic [15:0] interval_timer_preload;
  logic [15:0] interval_timer_remaining;
  logic [7:0] prescale;
  logic running;
  logic [NUM_EXT-1:0] ext_act;
  logic sync_raw;
  logic [DEB_W-1:0] deb_cnt;
  logic [DEB_W-1:0] deb_load;
  logic [NUM_IRQ-1:0] sources;
  logic [NUM_IRQ-1:0] src_prev;
  logic [NUM_IRQ-1:0] edges;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_go;
  logic rd_go;
  logic status_clear;
  logic [31:0] rd_value;
  logic rd_ok;
  logic tmr_wr;
  logic [15:0] tmr_data;
  logic tmr_start;

  function automatic logic sel(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    sel = (a == off);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // Write channel: address and data taken in either order
  assign wr_go = !awready && !wready && !bvalid;
  assign rd_go = arvalid && arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        wr_addr <= awaddr;
        awready <= 1'b0;
      end else if (bvalid && bready) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        wready <= 1'b0;
      end else if (bvalid && bready) begin
        wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      if (sel(wr_addr, OFF_POLARITY) || sel(wr_addr, OFF_CASC_SELECT) ||
          sel(wr_addr, OFF_DEBOUNCE) || sel(wr_addr, OFF_INT_ENABLE) ||
          sel(wr_addr, OFF_TIMER_PRELOAD)) begin
        bresp <= RESP_OKAY;
      end else begin
        bresp <= RESP_SLVERR;
      end
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read decode
  always_comb begin
    rd_value = 32'h0;
    rd_ok = 1'b1;
    if (sel(araddr, OFF_POLARITY)) begin
      rd_value = {24'h0, input_polarity_setting};
    end else if (sel(araddr, OFF_INPUT_STATE)) begin
      rd_value = {26'h0, ext_act}; // see R3
    end else if (sel(araddr, OFF_SYNC_STATE)) begin
      rd_value = {31'h0, sync_active}; // see R5
    end else if (sel(araddr, OFF_CASC_SELECT)) begin
      rd_value = {30'h0, cascade_source_select};
    end else if (sel(araddr, OFF_DEBOUNCE)) begin
      rd_value = {24'h0, sync_debounce_preload};
    end else if (sel(araddr, OFF_HW_REVISION)) begin
      rd_value = {24'h0, HW_REVISION}; // see R7
    end else if (sel(araddr, OFF_INT_ENABLE)) begin
      rd_value = {17'h0, interrupt_enable_word};
    end else if (sel(araddr, OFF_INT_STATUS)) begin
      rd_value = {17'h0, interrupt_status_word}; // see R12
    end else if (sel(araddr, OFF_TIMER_PRELOAD)) begin
      rd_value = {16'h0, interval_timer_preload};
    end else if (sel(araddr, OFF_TIMER_REMAIN)) begin
      rd_value = {16'h0, interval_timer_remaining}; // see R19
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (rd_go) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_value;
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_polarity_setting <= POLARITY_RESET;
      cascade_source_select <= CASC_OFF; // see R25
      sync_debounce_preload <= DEBOUNCE_RESET; // see R25
      interrupt_enable_word <= INT_ENABLE_RESET; // see R25
    end else if (wr_go) begin
      if (sel(wr_addr, OFF_POLARITY)) begin
        input_polarity_setting <= 8'(merge({24'h0, input_polarity_setting},
                                           wr_data, wr_strb));
      end else if (sel(wr_addr, OFF_CASC_SELECT)) begin
        cascade_source_select <= casc_src_e'(2'(merge(
          {30'h0, cascade_source_select}, wr_data, wr_strb)));
      end else if (sel(wr_addr, OFF_DEBOUNCE)) begin
        sync_debounce_preload <= 8'(merge({24'h0, sync_debounce_preload},
                                          wr_data, wr_strb)); // see R6
      end else if (sel(wr_addr, OFF_INT_ENABLE)) begin
        interrupt_enable_word <= 15'(merge({17'h0, interrupt_enable_word},
                                           wr_data, wr_strb)); // see R11
      end
    end
  end

  // Input sampling with polarity applied
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_act <= '0;
      sync_raw <= 1'b0;
    end else begin
      ext_act <= ~(ext_input ^ input_polarity_setting[NUM_EXT-1:0]); // see R1
      sync_raw <= ~(sync_input ^ input_polarity_setting[POL_SYNC_BIT]); // see R2
    end
  end

  // Sync drop-out delay
  assign deb_load = DEB_W'(sync_debounce_preload * DEBOUNCE_UNIT); // see R21

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deb_cnt <= '0;
      sync_active <= 1'b0;
    end else if (sync_debounce_preload == 8'h00) begin
      deb_cnt <= '0;
      sync_active <= sync_raw; // see R21
    end else if (sync_raw) begin
      deb_cnt <= deb_load; // see R22
      sync_active <= 1'b1;
    end else if (deb_cnt > DEB_W'(1)) begin
      deb_cnt <= deb_cnt - DEB_W'(1);
    end else begin
      deb_cnt <= '0;
      sync_active <= 1'b0; // see R22
    end
  end

  // Interval timer
  assign tmr_wr = wr_go && sel(wr_addr, OFF_TIMER_PRELOAD);
  assign tmr_data = 16'(merge({16'h0, interval_timer_preload}, wr_data,
                              wr_strb));
  assign tmr_start = tmr_wr && !running && (tmr_data != 16'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interval_timer_preload <= TIMER_PRELOAD_RESET;
      interval_timer_remaining <= 16'h0000;
      prescale <= 8'h00;
      running <= 1'b0; // see R25
      timer_zero_event <= 1'b0;
    end else begin
      timer_zero_event <= 1'b0;
      if (tmr_wr) begin
        interval_timer_preload <= tmr_data; // see R17
      end
      if (tmr_start) begin
        running <= 1'b1; // see R16
        prescale <= 8'h00;
        interval_timer_remaining <= tmr_data;
      end else if (running) begin
        prescale <= prescale + 8'h01; // see R18
        if (prescale == PRESCALE_LAST) begin
          if (interval_timer_remaining == 16'h0000) begin
            timer_zero_event <= 1'b1; // see R20
            interval_timer_remaining <= interval_timer_preload; // see R17
            if (interval_timer_preload == 16'h0000) begin
              running <= 1'b0; // see R15
            end
          end else begin
            interval_timer_remaining <= interval_timer_remaining - 16'h0001;
          end
        end
      end
    end
  end

  // Cascade output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cascade_output <= 1'b0;
    end else begin
      case (cascade_source_select) // see R4
        CASC_OFF: cascade_output <= !input_polarity_setting[POL_CASC_BIT];
        CASC_ON: cascade_output <= input_polarity_setting[POL_CASC_BIT];
        CASC_TIMER: cascade_output <= ~(timer_zero_event ^
                                        input_polarity_setting[POL_CASC_BIT]);
        default: cascade_output <= ~(sync_active ^
                                     input_polarity_setting[POL_CASC_BIT]);
      endcase
    end
  end

  // Interrupt capture
  assign sources = {encoder_error, ref_mark, ext_act, sync_active,
                    timer_zero_event}; // see R9
  // Reference marks ordered axis 0 first, second mark on the odd bit
  assign edges = sources & ~src_prev & interrupt_enable_word; // see R10
  assign status_clear = rd_go && sel(araddr, OFF_INT_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_prev <= '0;
      interrupt_status_word <= '0;
      irq <= 1'b0;
    end else begin
      src_prev <= sources; // see R14
      if (status_clear) begin
        interrupt_status_word <= edges; // see R13 R24
      end else begin
        interrupt_status_word <= interrupt_status_word | edges; // see R23
      end
      irq <= |interrupt_status_word; // see R8
    end
  end

  // Checks
  chk_status_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    status_clear && edges == '0 |=> interrupt_status_word == '0) // see R13
    else $error("status not cleared by read");
  chk_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    status_clear && edges != '0 |=>
    (interrupt_status_word & $past(edges)) == $past(edges)) // see R24
    else $error("edge lost on status read");
  chk_enable_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (interrupt_status_word & ~$past(interrupt_status_word) &
    ~$past(interrupt_enable_word)) == '0) // see R23
    else $error("disabled source set status");
  chk_edge_only: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (interrupt_status_word & ~$past(interrupt_status_word) &
    $past(src_prev)) == '0) // see R14
    else $error("steady source set status");
  chk_irq_or: assert property (@(posedge aclk) disable iff (!aresetn)
    edges != '0 |=> ##1 irq) // see R8
    else $error("irq missing after event");
  chk_timer_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_zero_event && $past(interval_timer_preload) == 16'h0000
    |-> !running) // see R15
    else $error("timer ran past zero preload");
  chk_timer_start: assert property (@(posedge aclk) disable iff (!aresetn)
    tmr_start |=> running && prescale == 8'h00 &&
    interval_timer_remaining == $past(tmr_data)) // see R16
    else $error("timer did not start");
  chk_timer_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    running && !tmr_start && prescale != PRESCALE_LAST |=>
    $stable(interval_timer_remaining)) // see R18
    else $error("remaining count moved mid step");
  chk_timer_event: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_zero_event |=> !timer_zero_event) // see R20
    else $error("timer event longer than a cycle");
  chk_sync_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_debounce_preload == 8'h00 |=> sync_active == $past(sync_raw))
    else $error("sync not passed through"); // see R21
  chk_sync_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_raw && sync_debounce_preload != 8'h00 |=> sync_active [*2])
    else $error("debounced sync dropped early"); // see R22
  chk_casc_off: assert property (@(posedge aclk) disable iff (!aresetn)
    cascade_source_select == CASC_OFF |=>
    cascade_output == !$past(input_polarity_setting[POL_CASC_BIT]))
    else $error("cascade not inactive"); // see R4

  cov_timer_event: cover property (@(posedge aclk) disable iff (!aresetn)
    timer_zero_event);
  cov_status_read: cover property (@(posedge aclk) disable iff (!aresetn)
    status_clear && interrupt_status_word != '0);
  cov_sync_drop: cover property (@(posedge aclk) disable iff (!aresetn)
    sync_debounce_preload != 8'h00 && $fell(sync_active));
  cov_casc_timer: cover property (@(posedge aclk) disable iff (!aresetn)
    cascade_source_select == CASC_TIMER && timer_zero_event);

endmodule // sync_io_interrupt_timer

/* sync_io_pkg.sv */
// Package with register map, field layout and timing constants
package sync_io_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_POLARITY = 8'h00;
  localparam logic [7:0] OFF_INPUT_STATE = 8'h04;
  localparam logic [7:0] OFF_SYNC_STATE = 8'h08;
  localparam logic [7:0] OFF_CASC_SELECT = 8'h0c;
  localparam logic [7:0] OFF_DEBOUNCE = 8'h10;
  localparam logic [7:0] OFF_HW_REVISION = 8'h14;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h18;
  localparam logic [7:0] OFF_INT_STATUS = 8'h1c;
  localparam logic [7:0] OFF_TIMER_PRELOAD = 8'h20;
  localparam logic [7:0] OFF_TIMER_REMAIN = 8'h24;
  localparam int NUM_EXT = 6;
  localparam int NUM_REF = 6;
  localparam int NUM_IRQ = 15;
  localparam int POL_SYNC_BIT = 6;
  localparam int POL_CASC_BIT = 7;
  localparam logic [7:0] POLARITY_RESET = 8'hff;
  localparam logic [7:0] DEBOUNCE_RESET = 8'h00;
  localparam logic [14:0] INT_ENABLE_RESET = 15'h0000;
  localparam logic [15:0] TIMER_PRELOAD_RESET = 16'h0000;
  // Arbitrary revision value
  localparam logic [7:0] HW_REVISION = 8'h01;
  localparam int TIMER_PRESCALE = 256;
  localparam logic [7:0] PRESCALE_LAST = 8'(TIMER_PRESCALE - 1);
  localparam int DEBOUNCE_UNIT_DEFAULT = 16384;
  localparam int DEB_W = 22;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    CASC_OFF,
    CASC_ON,
    CASC_TIMER,
    CASC_SYNC
  } casc_src_e;
endpackage

/* host_bus_model.sv */
// Host model: AXI4-Lite master that reaches the card registers
`timescale 1ns/100ps
module host_bus_model (
  input wire logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  int n_tx = 0;
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
  end
  // Answers late on two transfers out of three
  task automatic answer_wait;
    n_tx++;
    repeat (n_tx % 3) @(posedge aclk);
  endtask
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready) begin
        ad = 1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!wd && wready) begin
        wd = 1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    answer_wait();
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    answer_wait();
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
  endtask
endmodule // host_bus_model

/* sync_io_interrupt_timer_tb.sv */
// Testbench for the card control block driven over its register bus
`timescale 1ns/100ps
module sync_io_interrupt_timer_tb;
  import sync_io_pkg::*;
  localparam int UNIT = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic cascade_output, sync_active, timer_zero_event, irq;
  logic [5:0] ext_input = 6'h00;
  logic [5:0] ref_mark = 6'h00;
  logic sync_input = 1'b0;
  logic encoder_error = 1'b0;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];
  int exp_p[$];
  int n_errors = 0;
  int n_tests = 0;
  int seed = 32'hc498ab66;
  int cyc = 0;
  int last_ev = -1;
  int n_ev = 0;

  always #2.5 aclk = ~aclk;

  sync_io_interrupt_timer #(.DEBOUNCE_UNIT(UNIT)) i_sync_io_interrupt_timer (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_input(ext_input),
    .sync_input(sync_input), .ref_mark(ref_mark),
    .encoder_error(encoder_error), .cascade_output(cascade_output),
    .sync_active(sync_active), .timer_zero_event(timer_zero_event), .irq(irq)
  );

  host_bus_model i_host_bus_model (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rready(rready)
  );

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    exp_b.push_back(r);
    i_host_bus_model.write(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    exp_r.push_back({r, d});
    i_host_bus_model.read(a);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wait_ev;
    do @(posedge aclk); while (timer_zero_event !== 1'b1);
  endtask

  // Watches bus answers and timer crossings against queued notes
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (rvalid === 1'b1 && rready === 1'b1)
      check({rresp, rdata}, exp_r.size() ? exp_r.pop_front() : '1);
    if (bvalid === 1'b1 && bready === 1'b1)
      check(bresp, exp_b.size() ? exp_b.pop_front() : 2'h3);
    if (timer_zero_event === 1'b1) begin
      n_ev++;
      if (last_ev >= 0 && exp_p.size() > 0)
        check(cyc - last_ev, exp_p.pop_front());
      last_ev = cyc;
    end
  end

  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    final_report();
  end

  initial begin
    logic [7:0] p;
    logic [5:0] e;
    logic [14:0] m;
    logic s;
    logic act;
    int n;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFF_POLARITY, 32'hff, RESP_OKAY);
    rd(OFF_CASC_SELECT, 32'h0, RESP_OKAY);
    rd(OFF_DEBOUNCE, 32'h0, RESP_OKAY);
    rd(OFF_INT_ENABLE, 32'h0, RESP_OKAY);
    rd(OFF_TIMER_REMAIN, 32'h0, RESP_OKAY);
    wr(OFF_HW_REVISION, 32'h55, RESP_SLVERR);
    rd(OFF_HW_REVISION, {24'h0, HW_REVISION}, RESP_OKAY);
    rd(8'h28, 32'h0, RESP_SLVERR);
    wr(OFF_DEBOUNCE, 32'h1ff, RESP_OKAY);
    rd(OFF_DEBOUNCE, 32'hff, RESP_OKAY);
    wr(OFF_DEBOUNCE, 32'h0, RESP_OKAY);
    $display("test reset_map done");
    for (int i = 0; i < 4; i++) begin
      p = 8'($random(seed));
      e = 6'($random(seed));
      wr(OFF_POLARITY, {24'h0, p}, RESP_OKAY);
      ext_input <= e;
      cycles(4);
      rd(OFF_INPUT_STATE, {26'h0, ~(e ^ p[5:0])}, RESP_OKAY);
    end
    $display("test polarity done");
    for (int i = 0; i < 8; i++) begin
      s = 1'($random(seed));
      p = {i[2], 7'h7f};
      wr(OFF_POLARITY, {24'h0, p}, RESP_OKAY);
      wr(OFF_CASC_SELECT, 32'(i % 4), RESP_OKAY);
      sync_input <= s;
      cycles(4);
      rd(OFF_SYNC_STATE, {31'h0, s}, RESP_OKAY);
      act = (i % 4 == 1) || (i % 4 == 3 && s);
      check(cascade_output, p[7] ? act : !act);
    end
    $display("test cascade done");
    wr(OFF_POLARITY, 32'hff, RESP_OKAY);
    sync_input <= 1'b0;
    ext_input <= 6'h00;
    cycles(4);
    rd(OFF_INT_STATUS, 32'h0, RESP_OKAY);
    wr(OFF_DEBOUNCE, 32'h2, RESP_OKAY);
    wr(OFF_INT_ENABLE, 32'h2, RESP_OKAY);
    sync_input <= 1'b1;
    cycles(3);
    sync_input <= 1'b0;
    cycles(4);
    check(sync_active, 1'b1);
    sync_input <= 1'b1;
    cycles(1);
    sync_input <= 1'b0;
    cycles(6);
    check(sync_active, 1'b1);
    cycles(10);
    check(sync_active, 1'b0);
    check(irq, 1'b1);
    rd(OFF_INT_STATUS, 32'h2, RESP_OKAY);
    cycles(3);
    check(irq, 1'b0);
    wr(OFF_DEBOUNCE, 32'h0, RESP_OKAY);
    $display("test debounce done");
    m = 15'($random(seed)) & 15'h7ffc;
    wr(OFF_INT_ENABLE, {17'h0, m}, RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      ext_input <= 6'h3f;
      ref_mark <= 6'h3f;
      encoder_error <= 1'b1;
      cycles(4);
      check(irq, |m);
      rd(OFF_INT_STATUS, {17'h0, m}, RESP_OKAY);
      cycles(3);
      rd(OFF_INT_STATUS, 32'h0, RESP_OKAY);
      ext_input <= 6'h00;
      ref_mark <= 6'h00;
      encoder_error <= 1'b0;
      cycles(4);
    end
    wr(OFF_INT_ENABLE, 32'h4, RESP_OKAY);
    ext_input <= 6'h01;
    cycles(1);
    rd(OFF_INT_STATUS, 32'h0, RESP_OKAY);
    rd(OFF_INT_STATUS, 32'h4, RESP_OKAY);
    ext_input <= 6'h00;
    $display("test interrupts done");
    wr(OFF_INT_ENABLE, 32'h1, RESP_OKAY);
    wr(OFF_CASC_SELECT, 32'h2, RESP_OKAY);
    exp_p.push_back((2 + 1) * TIMER_PRESCALE);
    exp_p.push_back((1 + 1) * TIMER_PRESCALE);
    exp_p.push_back((1 + 1) * TIMER_PRESCALE);
    wr(OFF_TIMER_PRELOAD, 32'h2, RESP_OKAY);
    rd(OFF_TIMER_REMAIN, 32'h2, RESP_OKAY);
    wait_ev();
    #1;
    check(cascade_output, 1'b1);
    cycles(1);
    check(timer_zero_event, 1'b0);
    #1;
    check(cascade_output, 1'b0);
    cycles(1);
    wr(OFF_TIMER_PRELOAD, 32'h1, RESP_OKAY);
    wait_ev();
    wait_ev();
    rd(OFF_INT_STATUS, 32'h1, RESP_OKAY);
    wr(OFF_TIMER_PRELOAD, 32'h0, RESP_OKAY);
    wait_ev();
    cycles(1);
    n = n_ev;
    cycles(1500);
    check(n_ev, n);
    rd(OFF_TIMER_REMAIN, 32'h0, RESP_OKAY);
    check(exp_p.size(), 0);
    $display("test timer done");
    cycles(4);
    final_report();
  end
endmodule // sync_io_interrupt_timer_tb
